/* design/erbd_pkg.sv */
// erbd_pkg: constants shared by the receive buffer dma block.
// assumes a 32-bit register bus and a 32-bit bus-master port to memory.
package erbd_pkg;
	// ----------------------------------------
	// register byte offsets
	// ----------------------------------------
	localparam logic [7:0] ERBD_OFS_CTRL = 8'h00; // control
	localparam logic [7:0] ERBD_OFS_CFG  = 8'h04; // configuration
	localparam logic [7:0] ERBD_OFS_STAT = 8'h08; // receive status
	localparam logic [7:0] ERBD_OFS_QPTR = 8'h0C; // receive queue pointer
	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int ERBD_CTRL_RXEN   = 2;  // receive enable
	localparam int ERBD_CFG_OFS_LO  = 14; // first buffer offset, 2 bits
	localparam int ERBD_CFG_STRIP   = 17; // drop fcs bytes
	localparam int ERBD_ST_BNA      = 0;  // buffer not available
	localparam int ERBD_ST_FRM      = 1;  // frame received
	localparam int ERBD_ST_OVR      = 2;  // receive overrun
	localparam int ERBD_D0_OWN      = 0;  // descriptor used bit
	localparam int ERBD_D0_WRAP     = 1;  // descriptor wrap bit
	localparam int ERBD_D1_EOF      = 15; // status: end of frame
	localparam int ERBD_D1_SOF      = 14; // status: start of frame
	localparam int ERBD_D1_OFS_LO   = 12; // status: offset field
	localparam int ERBD_D1_VPRI_LO  = 17; // status: vlan priority
	localparam int ERBD_D1_PRIO     = 20; // status: priority tag
	localparam int ERBD_D1_VLAN     = 21; // status: vlan tag
	localparam int ERBD_D1_TYPE     = 22; // status: type id match
	localparam int ERBD_D1_SA_LO    = 23; // status: specific addr 4..1
	localparam int ERBD_D1_ADDR_LO  = 28; // status: ext,uni,multi,bcast
	// ----------------------------------------
	// sizes and reset values
	// ----------------------------------------
	localparam int ERBD_FIFO_WORDS  = 7;    // 28 bytes each
	localparam int ERBD_BURST       = 4;    // normal burst, words
	localparam int ERBD_RX_ROOM     = 3;    // room needed for rx request
	localparam int ERBD_TX_SHORT    = 2;    // room for short tx transfer
	localparam int ERBD_BUF_WORDS   = 32;   // 128-byte receive buffer
	localparam int ERBD_DESC_MAX    = 1024; // list rolls over here
	localparam int ERBD_FCS_BYTES   = 4;
	localparam logic [31:0] ERBD_RST_WORD = 32'h0000_0000;
	// dma sequencer states
	typedef enum logic [2:0] {
		ERBD_IDLE, ERBD_RD_DESC, ERBD_WR_DATA, ERBD_WR_STAT, ERBD_WR_OWN
	} erbd_state_e;
endpackage : erbd_pkg

/* design/erbd_top.sv */
// erbd_top: receive buffer dma and fifo request logic of the ethernet_mac_unit.
// assumes: mac hands over bytes synchronous to hclk; one memory master port
// answering each word with a one-cycle ack; ahb-lite register slave.
// How it works
// - rx fifo holds 28 bytes, tx fifo 24 of its 28
// - bus moves data in four-word bursts
// - rx request at four words, three free
// - tx request at room four, or two
// - every receive buffer is 128 bytes
// - list from queue pointer, word addresses
// - first buffer shifted by config offset
// - offset shrinks first buffer's capacity
// - descriptor is address word, status word
// - spilled buffer status: sof, offset only
// - full buffer marked used in bit 0
// - then fetch next descriptor, continue writing
// - full status only in last descriptor
// - buffer address from bits 31 to 2
// - bit 1 marks last list entry
// - write only unused buffers, then mark used
// - status bits 31..28 address matches
// - bits 26..23 specific matches, 27 reserved
// - bit 22 type match, 21 vlan
// - bit 20 priority tag
// - bits 19..17 vlan priority
// - bit 15 end, bit 14 start
// - bits 11..0 frame length
// - used descriptor sets buffer-not-available flag
`timescale 1ns/10ps
`default_nettype none
module erbd_top
	import erbd_pkg::*;
#(
	parameter int DEPTH = ERBD_FIFO_WORDS
)(
	// clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// ahb-lite register slave
	input  wire logic        hsel,
	input  wire logic [7:0]  haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// mac receive byte stream
	input  wire logic        rx_valid,
	input  wire logic [7:0]  rx_byte,
	input  wire logic        rx_sof,
	input  wire logic        rx_eof,
	input  wire logic        rx_fcs,
	// address checker results, held at eof
	input  wire logic [3:0]  rx_addr_hit,
	input  wire logic [3:0]  rx_sa_hit,
	input  wire logic        rx_type_hit,
	input  wire logic        rx_vlan,
	input  wire logic        rx_prio_tag,
	input  wire logic [2:0]  rx_vlan_pri,
	// transmit fifo: filled by tx dma, drained by mac
	input  wire logic        tx_fill_valid,
	input  wire logic [31:0] tx_fill_data,
	output logic             tx_fill_ready,
	input  wire logic        tx_next_short,
	input  wire logic        tx_take,
	output logic [31:0]      tx_data,
	output logic             tx_data_valid,
	output logic             tx_bus_req,
	// memory master port
	output logic             mem_req,
	output logic             mem_wr,
	output logic [31:0]      mem_addr,
	output logic [31:0]      mem_wdata,
	output logic [1:0]       mem_len,
	input  wire logic        mem_ack,
	input  wire logic [31:0] mem_rdata,
	// receive side bus request
	output logic             rx_bus_req
);
	localparam int PW = $clog2(DEPTH + 1);
	// ----------------------------------------
	// register file
	// ----------------------------------------
	logic [31:0] ctrl_reg, cfg_reg, qbase_reg;  // software registers
	logic [2:0]  stat_reg;                      // sticky status
	logic        ap_wr_reg;                     // write data phase pending
	logic [7:0]  ap_addr_reg;                   // latched address
	logic [9:0]  idx_reg;                       // current descriptor index
	logic        set_bna, set_frm, set_ovr;     // hardware set pulses
	logic        ap_take;
	logic [31:0] qptr;
	assign ap_take = hsel & htrans[1] & hready;
	assign qptr    = qbase_reg + {19'h0_0000, idx_reg, 3'h0};

	// address phase capture and read data, zero wait states
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn) begin
			ap_wr_reg   <= 1'b0;
			ap_addr_reg <= 8'h00;
			hrdata      <= ERBD_RST_WORD;
			hreadyout   <= 1'b1;
			hresp       <= 1'b0;
		end else begin
			ap_wr_reg <= ap_take & hwrite;
			if (ap_take)
				ap_addr_reg <= haddr;
			if (ap_take & ~hwrite) begin
				// unmapped reads answer zero
				if (haddr == ERBD_OFS_CTRL)
					hrdata <= ctrl_reg;
				else if (haddr == ERBD_OFS_CFG)
					hrdata <= cfg_reg;
				else if (haddr == ERBD_OFS_STAT)
					hrdata <= {29'h0000_0000, stat_reg};
				else if (haddr == ERBD_OFS_QPTR)
					hrdata <= qptr;
				else
					hrdata <= ERBD_RST_WORD;
			end
		end
	end

	// software-written registers
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn) begin
			ctrl_reg  <= ERBD_RST_WORD;
			cfg_reg   <= ERBD_RST_WORD;
			qbase_reg <= ERBD_RST_WORD;
		end else if (ap_wr_reg) begin
			if (ap_addr_reg == ERBD_OFS_CTRL)
				ctrl_reg <= hwdata;
			else if (ap_addr_reg == ERBD_OFS_CFG)
				cfg_reg <= hwdata;
			else if (ap_addr_reg == ERBD_OFS_QPTR)
				qbase_reg <= {hwdata[31:2], 2'b00}; // word aligned
		end
	end

	// sticky status, write one to clear; a set in the same cycle wins
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			stat_reg <= 3'h0;
		else begin
			if (ap_wr_reg && ap_addr_reg == ERBD_OFS_STAT)
				stat_reg <= stat_reg & ~hwdata[2:0] | {set_ovr, set_frm, set_bna};
			else
				stat_reg <= stat_reg | {set_ovr, set_frm, set_bna};
		end
	end

	// ----------------------------------------
	// receive byte packer
	// ----------------------------------------
	logic [31:0] pack_reg;          // partial word
	logic [1:0]  lane_reg;          // next byte lane
	logic        in_frm_reg;        // frame being taken
	logic        drop_reg;          // rest of frame discarded
	logic        done_reg;          // eof seen, status pending
	logic [11:0] len_reg;           // bytes stored so far
	logic [31:0] fstat_reg;         // match flags caught at eof
	logic [1:0]  fofs_reg;          // offset of this frame
	logic        acc, push, full, dma_idle, abort, owned_hit;
	logic [31:0] merged;
	logic [PW-1:0] rcnt_reg;

	assign full = (rcnt_reg == PW'(DEPTH));
	// fcs bytes are skipped when stripping, so length already excludes them
	assign acc  = rx_valid & ~drop_reg & (in_frm_reg | rx_sof)
		& ~(cfg_reg[ERBD_CFG_STRIP] & rx_fcs);
	always_comb
	begin
		merged = pack_reg;
		merged[{lane_reg, 3'b000} +: 8] = rx_byte;
	end
	assign push = (acc & lane_reg == 2'd3)
		| (rx_valid & rx_eof & in_frm_reg & ~drop_reg & (acc | lane_reg != 2'd0));

	// a frame starting while the previous is still being stored is lost:
	// one status slot keeps the logic small at the cost of back-to-back frames
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn) begin
			pack_reg   <= ERBD_RST_WORD;
			lane_reg   <= 2'd0;
			in_frm_reg <= 1'b0;
			drop_reg   <= 1'b0;
			done_reg   <= 1'b0;
			len_reg    <= 12'h000;
			fstat_reg  <= ERBD_RST_WORD;
			fofs_reg   <= 2'd0;
			set_ovr    <= 1'b0;
		end else begin
			set_ovr <= 1'b0;
			if (rx_valid & rx_sof & ctrl_reg[ERBD_CTRL_RXEN] & dma_idle & ~done_reg) begin
				// shifted start of the first buffer
				in_frm_reg <= 1'b1;
				drop_reg   <= 1'b0;
				fofs_reg   <= cfg_reg[ERBD_CFG_OFS_LO +: 2];
				lane_reg   <= cfg_reg[ERBD_CFG_OFS_LO +: 2] + 2'd1;
				pack_reg   <= ERBD_RST_WORD;
				pack_reg[{cfg_reg[ERBD_CFG_OFS_LO +: 2], 3'b000} +: 8] <= rx_byte;
				len_reg    <= 12'h001;
			end else if (in_frm_reg & rx_valid) begin
				if (acc) begin
					pack_reg <= merged;
					lane_reg <= lane_reg + 2'd1;
					len_reg  <= len_reg + 12'h001;
				end
				if (push & full & ~drop_reg) begin
					drop_reg <= 1'b1; // fifo overran: bus not granted in time
					set_ovr  <= 1'b1;
				end
				if (rx_eof) begin
					in_frm_reg <= 1'b0;
					done_reg   <= ~drop_reg & ~(push & full);
					fstat_reg  <= {rx_addr_hit, 1'b0, rx_sa_hit, rx_type_hit,
						rx_vlan, rx_prio_tag, rx_vlan_pri, 17'h0_0000};
				end
			end else if (abort)
				drop_reg <= 1'b1;
			if (dma_idle & done_reg & rcnt_reg == '0)
				done_reg <= 1'b0;
			if (abort) begin
				drop_reg <= 1'b1;
				done_reg <= 1'b0;
			end
			// software still owns the buffer: the frame is discarded
			if (owned_hit)
				drop_reg <= 1'b1;
		end
	end

	// ----------------------------------------
	// receive fifo, 28 bytes
	// ----------------------------------------
	logic [31:0]   rmem [DEPTH];
	logic [PW-1:0] rwr_reg, rrd_reg;
	logic          pop;
	function automatic logic [PW-1:0] inc(input logic [PW-1:0] p);
		return (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
	endfunction : inc

	// ring pointers; abort empties the ring
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn) begin
			rwr_reg  <= '0;
			rrd_reg  <= '0;
			rcnt_reg <= '0;
		end else if (abort) begin
			rwr_reg  <= '0;
			rrd_reg  <= '0;
			rcnt_reg <= '0;
		end else begin
			if (push & ~full & ~drop_reg)
				rwr_reg <= inc(rwr_reg);
			if (pop)
				rrd_reg <= inc(rrd_reg);
			rcnt_reg <= rcnt_reg + PW'(push & ~full & ~drop_reg) - PW'(pop);
		end
	end

	// storage only, no reset needed
	always_ff @(posedge hclk)
	begin
		if (push & ~full)
			rmem[rwr_reg] <= merged;
	end

	// receive request: four words held and room for three more
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			rx_bus_req <= 1'b0;
		else
			rx_bus_req <= (rcnt_reg >= PW'(ERBD_BURST))
				& (PW'(DEPTH) - rcnt_reg >= PW'(ERBD_RX_ROOM));
	end

	// ----------------------------------------
	// receive buffer manager
	// ----------------------------------------
	erbd_state_e st_reg;
	logic [31:0] buf_reg;    // current buffer start
	logic        wrap_reg;   // current descriptor is last in list
	logic        first_reg;  // first buffer of the frame
	logic        last_reg;   // status being written closes the frame
	logic [5:0]  wptr_reg;   // words written into the buffer
	logic [2:0]  left_reg;   // words left in the burst
	logic [31:0] stw_reg;    // status word to write
	logic [2:0]  room, nb;
	logic [2:0]  bnd;
	assign dma_idle = (st_reg == ERBD_IDLE);
	assign pop      = (st_reg == ERBD_WR_DATA) & mem_ack;
	assign abort    = (st_reg == ERBD_WR_DATA) & ~mem_req & drop_reg; // buffer recovered
	assign owned_hit = (st_reg == ERBD_RD_DESC) & mem_req & mem_ack & mem_rdata[ERBD_D0_OWN];
	// words until the buffer ends and the 16-byte line ends
	assign bnd  = 3'd4 - {1'b0, buf_reg[3:2] + wptr_reg[1:0]};
	always_comb
	begin
		room = (ERBD_BUF_WORDS - wptr_reg > 6'd3) ? 3'd4 : 3'(ERBD_BUF_WORDS - wptr_reg);
		nb   = (rcnt_reg < PW'(room)) ? 3'(rcnt_reg) : room;
		if (bnd < nb)
			nb = bnd;
	end

	// sequencer: fetch, data bursts, status, used bit, next descriptor
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn) begin
			st_reg    <= ERBD_IDLE;
			buf_reg   <= ERBD_RST_WORD;
			wrap_reg  <= 1'b0;
			first_reg <= 1'b0;
			last_reg  <= 1'b0;
			wptr_reg  <= 6'd0;
			left_reg  <= 3'd0;
			stw_reg   <= ERBD_RST_WORD;
			idx_reg   <= 10'd0;
			mem_req   <= 1'b0;
			mem_wr    <= 1'b0;
			mem_addr  <= ERBD_RST_WORD;
			mem_wdata <= ERBD_RST_WORD;
			mem_len   <= 2'd0;
			set_bna   <= 1'b0;
			set_frm   <= 1'b0;
		end else begin
			set_bna <= 1'b0;
			set_frm <= 1'b0;
			case (st_reg)
				ERBD_IDLE:
				begin
					// only a live frame starts a fetch: done_reg lingers one cycle here
					if (in_frm_reg & ~drop_reg) begin
						first_reg <= 1'b1;
						mem_req   <= 1'b1;
						mem_wr    <= 1'b0;
						mem_addr  <= qptr; // descriptor word 0
						mem_len   <= 2'd0;
						st_reg    <= ERBD_RD_DESC;
					end
				end
				ERBD_RD_DESC:
				begin
					if (!mem_req) begin
						// next descriptor of a spilled frame, after an idle cycle
						mem_req  <= 1'b1;
						mem_wr   <= 1'b0;
						mem_addr <= qptr;
						mem_len  <= 2'd0;
					end else if (mem_ack) begin
						mem_req <= 1'b0;
						if (mem_rdata[ERBD_D0_OWN]) begin
							set_bna <= 1'b1;  // buffer still owned by software
							st_reg  <= ERBD_WR_DATA; // drop then recovers
						end else begin
							buf_reg  <= {mem_rdata[31:2], 2'b00};
							wrap_reg <= mem_rdata[ERBD_D0_WRAP];
							wptr_reg <= 6'd0;
							st_reg   <= ERBD_WR_DATA;
						end
					end
				end
				ERBD_WR_DATA:
				begin
					if (mem_req) begin
						if (mem_ack) begin
							mem_addr  <= mem_addr + 32'h0000_0004;
							mem_wdata <= rmem[inc(rrd_reg)];
							wptr_reg  <= wptr_reg + 6'd1;
							left_reg  <= left_reg - 3'd1;
							if (left_reg == 3'd1)
								mem_req <= 1'b0;
						end
					end else if (drop_reg) begin
						st_reg <= ERBD_IDLE; // abort flushes the fifo
					end else if (wptr_reg == 6'(ERBD_BUF_WORDS) && (rcnt_reg != '0 || in_frm_reg)) begin
						// spilled buffer: only start flag and offset
						stw_reg <= ERBD_RST_WORD;
						stw_reg[ERBD_D1_SOF] <= first_reg;
						stw_reg[ERBD_D1_OFS_LO +: 2] <= first_reg ? fofs_reg : 2'd0;
						last_reg <= 1'b0;
						st_reg   <= ERBD_WR_STAT;
					end else if (done_reg && rcnt_reg == '0) begin
						// complete status in the last descriptor only
						stw_reg  <= fstat_reg | {16'h0000, 1'b1, first_reg,
							first_reg ? fofs_reg : 2'd0, len_reg};
						last_reg <= 1'b1;
						st_reg   <= ERBD_WR_STAT;
					end else if (nb != 3'd0 && (rx_bus_req || done_reg || nb == bnd)) begin
						// four-word bursts, shorter at line or buffer ends and at frame end
						mem_req   <= 1'b1;
						mem_wr    <= 1'b1;
						mem_addr  <= buf_reg + {24'h00_0000, wptr_reg, 2'b00};
						mem_wdata <= rmem[rrd_reg];
						mem_len   <= 2'(nb - 3'd1);
						left_reg  <= nb;
					end
				end
				ERBD_WR_STAT:
				begin
					if (!mem_req) begin
						mem_req   <= 1'b1;
						mem_wr    <= 1'b1;
						mem_addr  <= qptr + 32'h0000_0004; // status word
						mem_wdata <= stw_reg;
						mem_len   <= 2'd0;
					end else if (mem_ack) begin
						mem_req <= 1'b0;
						st_reg  <= ERBD_WR_OWN;
					end
				end
				ERBD_WR_OWN:
				begin
					if (!mem_req) begin
						mem_req   <= 1'b1;
						mem_addr  <= qptr;
						mem_wdata <= {buf_reg[31:2], wrap_reg, 1'b1}; // mark used
						mem_len   <= 2'd0;
					end else if (mem_ack) begin
						mem_req <= 1'b0;
						// wrap bit or 1024th entry returns to list start
						idx_reg <= (wrap_reg || idx_reg == 10'(ERBD_DESC_MAX - 1)) ? 10'd0
							: idx_reg + 10'd1;
						if (last_reg) begin
							set_frm <= 1'b1;
							st_reg  <= ERBD_IDLE;
						end else begin
							// continue the frame in the next buffer; the read goes out
							// from the new index once the request has dropped
							first_reg <= 1'b0;
							st_reg    <= ERBD_RD_DESC;
						end
					end
				end
				default:
					st_reg <= ERBD_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// transmit fifo, 28 bytes
	// ----------------------------------------
	logic [31:0]   tmem [DEPTH];
	logic [PW-1:0] twr_reg, trd_reg, tcnt_reg;
	logic          tpush, tpop;
	logic [PW-1:0] tcnt_next, trd_next;
	assign tpush     = tx_fill_valid & tx_fill_ready;
	assign tpop      = tx_take & tx_data_valid;
	assign tcnt_next = tcnt_reg + PW'(tpush) - PW'(tpop);
	assign trd_next  = tpop ? inc(trd_reg) : trd_reg;

	// storage only, no reset needed
	always_ff @(posedge hclk)
	begin
		if (tpush)
			tmem[twr_reg] <= tx_fill_data;
	end

	// pointers, registered handshakes and the transmit request
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn) begin
			twr_reg       <= '0;
			trd_reg       <= '0;
			tcnt_reg      <= '0;
			tx_fill_ready <= 1'b0;
			tx_data_valid <= 1'b0;
			tx_data       <= ERBD_RST_WORD;
			tx_bus_req    <= 1'b0;
		end else begin
			if (tpush)
				twr_reg <= inc(twr_reg);
			trd_reg       <= trd_next;
			tcnt_reg      <= tcnt_next;
			// ready from the next count; one slot held back so it stays honest
			tx_fill_ready <= tcnt_next < PW'(DEPTH - 1);
			// a word pushed into the head slot is shown through the bypass below
			tx_data_valid <= tcnt_next != '0;
			tx_data       <= (tpush && twr_reg == trd_next) ? tx_fill_data : tmem[trd_next];
			// room for four, or for two ahead of a short transfer
			tx_bus_req    <= (PW'(DEPTH) - tcnt_next >= PW'(ERBD_BURST))
				|| (tx_next_short && PW'(DEPTH) - tcnt_next >= PW'(ERBD_TX_SHORT));
		end
	end
endmodule : erbd_top
`default_nettype wire

/* test/erbd_assertions.sv */
// erbd_assertions: port checker for erbd_top, bound below.
// assumes one clock domain, hclk, with async active-low hresetn.
`timescale 1ns/10ps
`default_nettype none
module erbd_assertions
	import erbd_pkg::*;
(
	// clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// register bus
	input  wire logic        hsel,
	input  wire logic [7:0]  haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic        hready,
	input  wire logic [31:0] hrdata,
	input  wire logic        hreadyout,
	input  wire logic        hresp,
	// tx fifo and memory port
	input  wire logic        tx_fill_valid,
	input  wire logic        tx_fill_ready,
	input  wire logic        tx_data_valid,
	input  wire logic        mem_req,
	input  wire logic [31:0] mem_addr,
	input  wire logic [1:0]  mem_len,
	input  wire logic        mem_ack
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// ----------------------------------------
	// burst steps
	// ----------------------------------------
	sequence word_taken_s;
		mem_req && mem_ack;
	endsequence
	sequence next_word_s;
		word_taken_s ##1 mem_req;
	endsequence
	// ----------------------------------------
	// checks
	// ----------------------------------------
	zero_wait_a: assert property (hreadyout) else $error("slave stalled");
	okay_resp_a: assert property (!hresp) else $error("error response");
	unmapped_read_a: assert property (hsel && htrans[1] && hready && !hwrite && haddr >= 8'h10
		|=> hrdata == 32'h0000_0000) else $error("unmapped read not zero");
	burst_line_a: assert property ($rose(mem_req) |->
		({1'b0, mem_addr[3:2]} + {1'b0, mem_len}) <= 3'd3) else $error("burst crosses line");
	word_align_a: assert property (mem_req |-> mem_addr[1:0] == 2'b00)
		else $error("unaligned address");
	addr_step_a: assert property (next_word_s |-> mem_addr == $past(mem_addr) + 32'd4)
		else $error("address did not step");
	req_hold_a: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
		else $error("request dropped early");
	tx_valid_a: assert property (tx_fill_valid && tx_fill_ready |=> tx_data_valid)
		else $error("pushed word not shown");
endmodule : erbd_assertions
bind erbd_top erbd_assertions u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
	.hresp(hresp), .tx_fill_valid(tx_fill_valid), .tx_fill_ready(tx_fill_ready),
	.tx_data_valid(tx_data_valid), .mem_req(mem_req), .mem_addr(mem_addr),
	.mem_len(mem_len), .mem_ack(mem_ack));
`default_nettype wire

/* test/erbd_mem_model.sv */
// erbd_mem_model: system memory behind the dma master port.
// assumes word requests held until ack; 1 KiB of memory seen.
`timescale 1ns/10ps
`default_nettype none
module erbd_mem_model
(
	// clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// stall control from the bench
	input  wire logic        slow,
	// master port
	input  wire logic        mem_req,
	input  wire logic        mem_wr,
	input  wire logic [31:0] mem_addr,
	input  wire logic [31:0] mem_wdata,
	output logic             mem_ack,
	output logic [31:0]      mem_rdata
);
	logic [31:0] m [0:255]; // word array, filled by the bench
	logic        tog;       // stall phase in slow mode
	// one word per ack, never two acks back to back
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			mem_ack <= 1'b0;
			tog     <= 1'b0;
		end
		else
		begin
			tog     <= ~tog;
			mem_ack <= mem_req && !mem_ack && !(slow && tog);
		end
	end
	// plain always: the bench also loads descriptors here
	always @(posedge hclk)
	begin
		if (mem_req && mem_ack && mem_wr)
			m[mem_addr[9:2]] <= mem_wdata;
	end
	// outside an ack the data is inverted so a stale word never passes
	assign mem_rdata = mem_ack ? m[mem_addr[9:2]] : ~m[mem_addr[9:2]];
endmodule : erbd_mem_model
`default_nettype wire

/* test/ethernet_rx_buffer_dma_tb_top.sv */
// ethernet_rx_buffer_dma_tb_top: register-task bench for erbd_top.
// assumes little-endian byte lanes and descriptors at address 0.
`timescale 1ns/10ps
`default_nettype none
module ethernet_rx_buffer_dma_tb_top;
	import erbd_pkg::*;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	logic        hclk, hresetn, hsel, hwrite, rx_valid, rx_sof, rx_eof, rx_fcs, slow;
	logic        rx_type_hit, rx_vlan, rx_prio_tag, tx_fill_valid, tx_next_short, tx_take;
	logic [1:0]  htrans;
	logic [2:0]  hsize, rx_vlan_pri;
	logic [3:0]  rx_addr_hit, rx_sa_hit;
	logic [7:0]  haddr, rx_byte;
	logic [31:0] hwdata, tx_fill_data, st;
	wire logic   hready;
	logic [31:0] hrdata, tx_data, mem_addr, mem_wdata, mem_rdata;
	logic [1:0]  mem_len;
	logic        hreadyout, hresp, tx_fill_ready, tx_data_valid, tx_bus_req;
	logic        mem_req, mem_wr, mem_ack, rx_bus_req;
	int          failures, comparisons, i;
	assign hready = hreadyout; // single slave: its ready is the bus ready
	erbd_top u_dut (.*);
	erbd_mem_model u_mem (.hclk(hclk), .hresetn(hresetn), .slow(slow), .mem_req(mem_req),
		.mem_wr(mem_wr), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
		.mem_rdata(mem_rdata));
	always #10 hclk = ~hclk; // 50 MHz
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		comparisons++;
		if (got !== exp)
		begin
			failures++;
			$display("unexpected at %0t: %s got %h", $time, what, got);
		end
	endtask : chk
	task automatic close_out;
		$display("failures %0d comparisons %0d", failures, comparisons);
		if (failures == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : close_out
	// one single ahb-lite word; q is the read data of a read
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge hclk);
		hsel   <= 1'b1;
		haddr  <= a;
		htrans <= 2'b10;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask : ahb
	// one byte every four cycles, then wait for a status flag and clear it
	task automatic frame(input int n, input logic [31:0] mask);
		for (int k = 0; k < n; k++)
		begin
			@(posedge hclk);
			rx_valid <= 1'b1;
			rx_byte  <= 8'(k + 1);
			rx_sof   <= (k == 0);
			rx_eof   <= (k == n - 1);
			@(posedge hclk);
			rx_valid <= 1'b0;
			repeat (2) @(posedge hclk);
		end
		st = 32'h0000_0000;
		for (int k = 0; k < 400 && (st & mask) == 0; k++)
			ahb(1'b0, ERBD_OFS_STAT, 0, st);
		chk(st & mask, mask, "status flag");
		ahb(1'b1, ERBD_OFS_STAT, 32'h0000_0007, st);
	endtask : frame
	function automatic logic [7:0] mbyte(input int a);
		return u_mem.m[a / 4][8 * (a % 4) +: 8];
	endfunction : mbyte
	task automatic push(input logic [31:0] d);
		@(posedge hclk);
		tx_fill_valid <= 1'b1;
		tx_fill_data  <= d;
		do @(posedge hclk); while (tx_fill_ready !== 1'b1);
		tx_fill_valid <= 1'b0;
	endtask : push
	// ----------------------------------------
	// watchdog: the whole run needs about a thousand cycles
	// ----------------------------------------
	initial
	begin
		repeat (20000) @(posedge hclk);
		failures++;
		close_out();
	end
	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial
	begin
		{hclk, hresetn, hsel, hwrite, rx_valid, rx_sof, rx_eof, rx_fcs, slow} = 0;
		{rx_type_hit, rx_vlan, rx_prio_tag, tx_fill_valid, tx_next_short, tx_take} = 0;
		{htrans, rx_vlan_pri, rx_addr_hit, rx_sa_hit, haddr, rx_byte} = 0;
		{hwdata, tx_fill_data} = 0;
		hsize = 3'h2;
		failures = 0;
		comparisons = 0;
		// three descriptors, the last one wraps
		u_mem.m[0] = 32'h0000_0100;
		u_mem.m[2] = 32'h0000_0180;
		u_mem.m[4] = 32'h0000_0202;
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (2) @(posedge hclk);
		chk(tx_bus_req, 1'b1, "tx request empty");
		ahb(1'b1, ERBD_OFS_QPTR, 32'h0000_0000, st);
		ahb(1'b1, ERBD_OFS_CFG, 32'h0000_8000, st);
		ahb(1'b1, ERBD_OFS_CTRL, 32'h0000_0004, st);
		rx_addr_hit <= 4'hA;
		rx_sa_hit   <= 4'h5;
		rx_type_hit <= 1'b1;
		rx_vlan     <= 1'b1;
		rx_vlan_pri <= 3'h5;
		frame(10, 32'h0000_0002);
		chk(u_mem.m[1], 32'hA2EA_E00A, "whole frame status");
		chk(u_mem.m[0], 32'h0000_0101, "used bit");
		chk(mbyte(32'h102), 8'h01, "first byte offset");
		chk(mbyte(32'h10B), 8'h0A, "last byte");
		slow <= 1'b1;
		frame(140, 32'h0000_0002);
		chk(u_mem.m[3], 32'h0000_6000, "spilled status");
		chk(u_mem.m[2], 32'h0000_0181, "spilled used");
		chk(mbyte(32'h1FF), 8'd126, "first buffer end");
		chk(mbyte(32'h200), 8'd127, "next buffer start");
		chk(u_mem.m[5][15:0], 16'h808C, "last status");
		chk(u_mem.m[4], 32'h0000_0203, "wrap kept");
		ahb(1'b0, ERBD_OFS_QPTR, 0, st);
		chk(st, 32'h0000_0000, "index wrapped");
		frame(8, 32'h0000_0001);
		chk(mbyte(32'h102), 8'h01, "owned buffer untouched");
		chk(u_mem.m[1], 32'hA2EA_E00A, "owned status kept");
		ahb(1'b0, ERBD_OFS_STAT, 0, st);
		chk(st, 32'h0000_0000, "status cleared");
		ahb(1'b0, 8'h10, 0, st);
		chk(st, 32'h0000_0000, "unmapped read");
		for (i = 0; i < 4; i++)
			push(32'h0000_1000 + i);
		repeat (3) @(posedge hclk);
		chk(tx_bus_req, 1'b0, "room three");
		tx_next_short <= 1'b1;
		repeat (3) @(posedge hclk);
		chk(tx_bus_req, 1'b1, "short request");
		push(32'h0000_1004);
		push(32'h0000_1005);
		repeat (3) @(posedge hclk);
		chk(tx_fill_ready, 1'b0, "tx fifo full");
		chk(tx_bus_req, 1'b0, "room one");
		for (i = 0; i < 6; i++)
		begin
			chk(tx_data, 32'h0000_1000 + i, "tx order");
			@(posedge hclk);
			tx_take <= 1'b1;
			@(posedge hclk);
			tx_take <= 1'b0;
			repeat (2) @(posedge hclk);
		end
		close_out();
	end
endmodule : ethernet_rx_buffer_dma_tb_top
`default_nettype wire
